// ---- psc_stage.sv ----
// Function
// RL1: Mode 0: signed value above pick-up
// RL2: Mode 1: absolute value above pick-up
// RL3: Mode 2: signed value below pick-up
// RL4: Mode 3: absolute value below pick-up
// RL5: Under modes inactive below blocking limit
// RL6: Mode 4: directional relative change in 20ms
// RL7: Mode 5: relative change either direction
// RL8: Mode 6: directional absolute change in 20ms
// RL9: Mode 7: absolute change either direction
// RL10: Own signed pick-up per comparison
// RL11: Own hysteresis per level, 3% reset
// RL12: Settable operate and release delays
// RL13: Blocking sampled at each cycle start
// RL14: Pick-up unblocked asserts start, runs timer
// RL15: Pick-up blocked asserts blocked, no start
// RL16: Late blocking drops start, release timing
// RL17: Blocking gives display and recorded event
// RL18: Test mode lets software drive blocking
// RL19: Source asserts blocking 5ms before operate
// RL20: ON/OFF events, mask selects stored kinds; masks gate only evt_o, history stores every ON record
// RL21: Circular history of twelve ON records
// RL22: Record: time, event, magnitude, ratio, remain, group
// RL23: Condition: normal 0 start 1 trip 2 blocked 3
// RL24: Hysteresis relative to pick-up value
// RL25: Trip after operate delay, clear after release
// RL26: Comparisons combined into one stage pick-up
module psc_stage #(
    parameter int MS_CYCLES = psc_pkg::MS_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire psc_pkg::psc_meas_t meas_i,
    input wire logic block_i,
    input wire logic [31:0] ts_i,
    output logic start_o,
    output logic trip_o,
    output logic blocked_o,
    output logic [1:0] cond_o,
    output logic [5:0] evt_o,
    output logic disp_evt_o
);
    import psc_pkg::*;

    // =========================================================
    // Helpers
    function automatic logic signed [63:0] sabs(input logic signed [63:0] v);
        return (v < 0) ? -v : v;
    endfunction

    function automatic logic arr_hit(input logic [7:0] a, input logic [7:0] base);
        return (a >= base) && (a < base + ARR_SPAN);
    endfunction

    function automatic int arr_idx(input logic [7:0] a, input logic [7:0] base);
        return int'((a - base) >> 2);
    endfunction

    function automatic logic cmp_eval(
        input psc_mode_t mode,
        input logic signed [63:0] val,
        input logic signed [63:0] ref_v,
        input logic signed [63:0] pu,
        input logic signed [63:0] hy,
        input logic signed [63:0] bl,
        input logic act
    );
        logic signed [63:0] x;
        logic signed [63:0] t;
        logic signed [63:0] h;
        logic signed [63:0] d;
        logic under;
        h = sabs(pu) * hy / HY_FULL; // [RL24]
        d = val - ref_v;
        x = val;
        t = pu;
        under = 1'b0;
        unique case (mode)
            MODE_OVER: x = val; // [RL1]
            MODE_OVER_ABS: x = sabs(val); // [RL2]
            MODE_UNDER: under = 1'b1; // [RL3]
            MODE_UNDER_ABS: begin
                x = sabs(val); // [RL4]
                under = 1'b1;
            end
            MODE_DPCT: begin
                x = (pu < 0) ? -d : d; // [RL6]
                t = sabs(ref_v) * sabs(pu) / PCT_FULL;
            end
            MODE_DPCT_ABS: begin
                x = sabs(d); // [RL7]
                t = sabs(ref_v) * sabs(pu) / PCT_FULL;
            end
            MODE_DVAL: begin
                x = (pu < 0) ? -d : d; // [RL8]
                t = sabs(pu);
            end
            MODE_DVAL_ABS: begin
                x = sabs(d); // [RL9]
                t = sabs(pu);
            end
        endcase
        if (under) begin
            return (x >= bl) && (act ? (x < t + h) : (x < t)); // [RL5] [RL11]
        end
        return act ? (x > t - h) : (x > t); // [RL11]
    endfunction

    // =========================================================
    // Registers
    logic [31:0] ctrl_reg;
    logic [NCMP*MODE_W-1:0] mode_reg;
    logic signed [31:0] pu_reg [NCMP];
    logic [31:0] hy_reg [NCMP];
    logic signed [31:0] bl_reg [NCMP];
    logic [31:0] opd_reg;
    logic [31:0] rld_reg;
    logic [HAW-1:0] hsel_reg;
    logic [HAW-1:0] hptr_reg;
    logic [HAW-1:0] hcnt_reg;
    logic pready_reg;

    wire logic acc = psel_i & penable_i & ~pready_reg;
    wire logic wr = acc & pwrite_i;
    wire logic hit_pu = arr_hit(paddr_i, OFS_PU0);
    wire logic hit_hy = arr_hit(paddr_i, OFS_HY0);
    wire logic hit_bl = arr_hit(paddr_i, OFS_BL0);
    wire integer ai_pu = arr_idx(paddr_i, OFS_PU0);
    wire integer ai_hy = arr_idx(paddr_i, OFS_HY0);
    wire integer ai_bl = arr_idx(paddr_i, OFS_BL0);
    wire logic hit_rw = (paddr_i == OFS_CTRL) | (paddr_i == OFS_MODE)
        | hit_pu | hit_hy | hit_bl | (paddr_i == OFS_OPD)
        | (paddr_i == OFS_RLD) | (paddr_i == OFS_HSEL);
    wire logic hit_ro = (paddr_i == OFS_STAT) | (paddr_i == OFS_REM)
        | (paddr_i == OFS_HCNT) | (paddr_i == OFS_HTS)
        | (paddr_i == OFS_HEVT) | (paddr_i == OFS_HMAG)
        | (paddr_i == OFS_HRAT);
    wire logic bad = (paddr_i[1:0] != 2'h0) | ~(hit_rw | (hit_ro & ~pwrite_i));
    wire logic [31:0] dly_w = (pwdata_i > DLY_MAX) ? DLY_MAX : pwdata_i;

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            ctrl_reg <= CTRL_RST;
            mode_reg <= '0;
            for (int i = 0; i < NCMP; i++) begin
                pu_reg[i] <= PU_RST; // [RL10]
                hy_reg[i] <= HY_RST; // [RL11]
                bl_reg[i] <= '0;
            end
            opd_reg <= OPD_RST;
            rld_reg <= RLD_RST;
            hsel_reg <= '0;
        end else if (wr && !bad) begin
            if (paddr_i == OFS_CTRL) ctrl_reg <= pwdata_i;
            if (paddr_i == OFS_MODE) mode_reg <= pwdata_i[NCMP*MODE_W-1:0];
            if (hit_pu) pu_reg[ai_pu] <= pwdata_i; // [RL10]
            if (hit_hy) hy_reg[ai_hy] <= pwdata_i; // [RL11]
            if (hit_bl) bl_reg[ai_bl] <= pwdata_i; // [RL5]
            if (paddr_i == OFS_OPD) opd_reg <= dly_w; // [RL12]
            if (paddr_i == OFS_RLD) rld_reg <= dly_w; // [RL12]
            if (paddr_i == OFS_HSEL) hsel_reg <= pwdata_i[HAW-1:0];
        end
    end

    // =========================================================
    // Program cycle evaluation
    logic signed [31:0] ref_reg [NCMP];
    logic [NCMP-1:0] act_reg;
    logic pick_reg;
    logic blk_reg;
    logic signed [31:0] mag_reg;
    logic [NCMP-1:0] ful;

    always_comb begin
        for (int i = 0; i < NCMP; i++) begin
            ful[i] = cmp_eval(psc_mode_t'(mode_reg[i*MODE_W +: MODE_W]),
                64'(signed'(meas_i.val[i])), 64'(ref_reg[i]), 64'(pu_reg[i]),
                64'(hy_reg[i]), 64'(bl_reg[i]), act_reg[i]);
        end
    end

    wire logic [NCMP-1:0] en = ctrl_reg[CT_EN_LO +: NCMP];
    wire logic pick_all = ((ful & en) == en) && (en != '0);
    wire logic pick_any = |(ful & en);
    wire logic pick_now = ctrl_reg[CT_AND] ? pick_all : pick_any; // [RL26]
    wire logic blk_src = ctrl_reg[CT_FORCE_EN] ? ctrl_reg[CT_FORCE_BLK] : block_i; // [RL18]

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            act_reg <= '0;
            pick_reg <= 1'b0;
            blk_reg <= 1'b0;
            mag_reg <= '0;
        end else if (meas_i.cycle) begin
            blk_reg <= blk_src; // [RL13]
            act_reg <= ful;
            pick_reg <= pick_now; // [RL26]
            mag_reg <= meas_i.val[0];
        end
    end

    // =========================================================
    // Millisecond tick and 20 ms reference window
    logic [$clog2(MS_CYCLES+1)-1:0] pre_reg;
    logic [$clog2(WIN_MS+1)-1:0] win_reg;
    wire logic ms_tick = (pre_reg == ($clog2(MS_CYCLES+1))'(MS_CYCLES - 1));
    wire logic win_end = ms_tick && (win_reg == ($clog2(WIN_MS+1))'(WIN_MS - 1));

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            pre_reg <= '0;
            win_reg <= '0;
            for (int i = 0; i < NCMP; i++) ref_reg[i] <= '0;
        end else begin
            pre_reg <= ms_tick ? '0 : pre_reg + 1'b1;
            if (ms_tick) win_reg <= win_end ? '0 : win_reg + 1'b1;
            if (win_end) begin
                for (int i = 0; i < NCMP; i++) ref_reg[i] <= meas_i.val[i]; // [RL6] [RL8]
            end
        end
    end

    // =========================================================
    // Start, trip and blocked
    logic start_reg;
    logic trip_reg;
    logic blocked_reg;
    logic [31:0] op_cnt_reg;
    logic [31:0] rel_cnt_reg;

    wire logic start_next = pick_reg & ~blk_reg; // [RL14]
    wire logic blocked_next = pick_reg & blk_reg; // [RL15]
    wire logic op_done = start_reg && (op_cnt_reg >= opd_reg); // [RL25]
    wire logic rel_run = ~start_reg & (trip_reg | (op_cnt_reg != '0));
    wire logic rel_done = rel_run && (rel_cnt_reg >= rld_reg); // [RL16] [RL25]
    wire logic [31:0] remain = start_reg && !op_done ? opd_reg - op_cnt_reg : '0;
    wire logic [1:0] cond_next = trip_reg ? COND_TRIP
        : blocked_reg ? COND_BLOCKED : start_reg ? COND_START : COND_NORMAL; // [RL23]

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            start_reg <= 1'b0;
            trip_reg <= 1'b0;
            blocked_reg <= 1'b0;
            op_cnt_reg <= '0;
            rel_cnt_reg <= '0;
        end else begin
            start_reg <= start_next; // [RL14] [RL15] [RL16]
            blocked_reg <= blocked_next; // [RL15]
            if (op_done) begin
                trip_reg <= 1'b1; // [RL25]
            end else if (rel_done) begin
                trip_reg <= 1'b0; // [RL25]
            end
            if (start_reg && !op_done && ms_tick) begin
                op_cnt_reg <= op_cnt_reg + 1'b1; // [RL14]
            end else if (rel_done) begin
                op_cnt_reg <= '0;
            end
            if (!rel_run || rel_done) begin
                rel_cnt_reg <= '0;
            end else if (ms_tick) begin
                rel_cnt_reg <= rel_cnt_reg + 1'b1; // [RL16]
            end
        end
    end

    // =========================================================
    // Events and history
    logic start_d_reg;
    logic trip_d_reg;
    logic blocked_d_reg;
    wire logic [2:0] now_v = {blocked_reg, trip_reg, start_reg};
    wire logic [2:0] old_v = {blocked_d_reg, trip_d_reg, start_d_reg};
    wire logic [2:0] on_v = now_v & ~old_v;
    wire logic [2:0] off_v = ~now_v & old_v;
    wire logic mon = ctrl_reg[CT_MASK_ON];
    wire logic moff = ctrl_reg[CT_MASK_OFF];
    wire logic [5:0] evt_next = {off_v[2] & moff, on_v[2] & mon, off_v[1] & moff,
        on_v[1] & mon, off_v[0] & moff, on_v[0] & mon}; // [RL20]
    wire logic [2:0] rec_code = on_v[1] ? EV_TRIP_ON
        : on_v[2] ? EV_BLOCK_ON : EV_START_ON;
    wire logic signed [63:0] ratio_w = (pu_reg[0] == 0) ? '0
        : (64'(mag_reg) <<< RAT_SH) / 64'(pu_reg[0]);
    psc_rec_t rec_w;
    psc_rec_t hrec;

    assign rec_w = '{ts: ts_i, code: rec_code, fault: act_reg,
        sg: ctrl_reg[CT_SG_LO +: 3], remain: remain[REMW-1:0],
        mag: mag_reg, ratio: ratio_w[31:0]}; // [RL22] [RL17]

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            start_d_reg <= 1'b0;
            trip_d_reg <= 1'b0;
            blocked_d_reg <= 1'b0;
            hptr_reg <= '0;
            hcnt_reg <= '0;
        end else begin
            start_d_reg <= start_reg;
            trip_d_reg <= trip_reg;
            blocked_d_reg <= blocked_reg;
            if (on_v != '0) begin
                hptr_reg <= (hptr_reg == HAW'(HDEPTH - 1)) ? '0 : hptr_reg + 1'b1; // [RL21]
                if (hcnt_reg != HAW'(HDEPTH)) hcnt_reg <= hcnt_reg + 1'b1;
            end
        end
    end

    psc_hist_mem #(
        .DEPTH(HDEPTH),
        .AW(HAW)
    ) u_hist (
        .mclk_i(mclk_i),
        .we_i(on_v != '0), // [RL21]
        .waddr_i(hptr_reg),
        .wdata_i(rec_w),
        .raddr_i(hsel_reg),
        .rdata_o(hrec)
    );

    // =========================================================
    // Read data
    wire logic [31:0] rd_word =
        (paddr_i == OFS_CTRL) ? ctrl_reg
        : (paddr_i == OFS_MODE) ? 32'(mode_reg)
        : hit_pu ? pu_reg[ai_pu]
        : hit_hy ? hy_reg[ai_hy]
        : hit_bl ? bl_reg[ai_bl]
        : (paddr_i == OFS_OPD) ? opd_reg
        : (paddr_i == OFS_RLD) ? rld_reg
        : (paddr_i == OFS_STAT) ? {27'h0, blocked_reg, trip_reg, start_reg, cond_o}
        : (paddr_i == OFS_REM) ? remain
        : (paddr_i == OFS_HCNT) ? {24'h0, hptr_reg, hcnt_reg}
        : (paddr_i == OFS_HSEL) ? 32'(hsel_reg)
        : (paddr_i == OFS_HTS) ? hrec.ts
        : (paddr_i == OFS_HEVT) ? {hrec.code, hrec.fault, hrec.sg, 2'h0, hrec.remain}
        : (paddr_i == OFS_HMAG) ? hrec.mag
        : (paddr_i == OFS_HRAT) ? hrec.ratio : 32'h0;

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            pready_reg <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= '0;
            start_o <= 1'b0;
            trip_o <= 1'b0;
            blocked_o <= 1'b0;
            cond_o <= COND_NORMAL;
            evt_o <= '0;
            disp_evt_o <= 1'b0;
        end else begin
            pready_reg <= acc;
            pslverr_o <= acc & bad;
            if (acc && !pwrite_i) prdata_o <= bad ? '0 : rd_word;
            start_o <= start_reg;
            trip_o <= trip_reg;
            blocked_o <= blocked_reg;
            cond_o <= cond_next; // [RL23]
            evt_o <= evt_next; // [RL20]
            disp_evt_o <= on_v[2]; // [RL17]
        end
    end

    assign pready_o = pready_reg;
endmodule

// ---- psc_pkg.sv ----
package psc_pkg;
    // =========================================================
    // Sizes
    localparam int NCMP = 3;
    localparam int DW = 32;
    localparam int HDEPTH = 12;
    localparam int HAW = 4;
    localparam int REMW = 21;

    // =========================================================
    // Register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_PU0 = 8'h08;
    localparam logic [7:0] OFS_HY0 = 8'h14;
    localparam logic [7:0] OFS_BL0 = 8'h20;
    localparam logic [7:0] OFS_OPD = 8'h2C;
    localparam logic [7:0] OFS_RLD = 8'h30;
    localparam logic [7:0] OFS_STAT = 8'h34;
    localparam logic [7:0] OFS_REM = 8'h38;
    localparam logic [7:0] OFS_HCNT = 8'h3C;
    localparam logic [7:0] OFS_HSEL = 8'h40;
    localparam logic [7:0] OFS_HTS = 8'h44;
    localparam logic [7:0] OFS_HEVT = 8'h48;
    localparam logic [7:0] OFS_HMAG = 8'h4C;
    localparam logic [7:0] OFS_HRAT = 8'h50;
    localparam logic [7:0] ARR_SPAN = 8'h0C;

    // =========================================================
    // Control fields
    localparam int CT_FORCE_EN = 0;
    localparam int CT_FORCE_BLK = 1;
    localparam int CT_MASK_ON = 2;
    localparam int CT_MASK_OFF = 3;
    localparam int CT_AND = 4;
    localparam int CT_SG_LO = 5;
    localparam int CT_EN_LO = 8;
    localparam int MODE_W = 3;

    // =========================================================
    // Reset values and scales
    localparam logic [31:0] CTRL_RST = 32'h0000_072C;
    localparam logic [31:0] PU_RST = 32'h0000_0001;
    localparam logic [31:0] HY_RST = 32'h0000_7530;
    localparam logic [31:0] OPD_RST = 32'h0000_0028;
    localparam logic [31:0] RLD_RST = 32'h0000_003C;
    localparam logic [31:0] DLY_MAX = 32'h001B_7740;
    localparam logic signed [63:0] HY_FULL = 64'h0000_0000_000F_4240;
    localparam logic signed [63:0] PCT_FULL = 64'h0000_0000_0000_2710;
    localparam int RAT_SH = 8;

    // =========================================================
    // Timing
    localparam int CLK_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int MS_CYC = MS_NS / CLK_NS;
    localparam int WIN_MS = 20;

    // =========================================================
    // Condition codes and event bits
    localparam logic [1:0] COND_NORMAL = 2'h0;
    localparam logic [1:0] COND_START = 2'h1;
    localparam logic [1:0] COND_TRIP = 2'h2;
    localparam logic [1:0] COND_BLOCKED = 2'h3;
    localparam logic [2:0] EV_START_ON = 3'h0;
    localparam logic [2:0] EV_TRIP_ON = 3'h2;
    localparam logic [2:0] EV_BLOCK_ON = 3'h4;

    typedef enum logic [2:0] {
        MODE_OVER, MODE_OVER_ABS, MODE_UNDER, MODE_UNDER_ABS,
        MODE_DPCT, MODE_DPCT_ABS, MODE_DVAL, MODE_DVAL_ABS
    } psc_mode_t;

    typedef struct packed {
        logic [31:0] ts;
        logic [2:0] code;
        logic [NCMP-1:0] fault;
        logic [2:0] sg;
        logic [REMW-1:0] remain;
        logic [31:0] mag;
        logic [31:0] ratio;
    } psc_rec_t;

    typedef struct packed {
        logic cycle;
        logic [NCMP-1:0][31:0] val;
    } psc_meas_t;
endpackage

// ---- psc_hist_mem.sv ----
module psc_hist_mem #(
    parameter int DEPTH = psc_pkg::HDEPTH,
    parameter int AW = psc_pkg::HAW
) (
    input wire logic mclk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire psc_pkg::psc_rec_t wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output psc_pkg::psc_rec_t rdata_o
);
    import psc_pkg::*;

    // =========================================================
    // Storage with registered read
    psc_rec_t mem [DEPTH];

    always_ff @(posedge mclk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule

// ---- psc_stage_properties.sv ----
module psc_stage_properties #(
    parameter int MS_CYCLES = 10
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire psc_pkg::psc_meas_t meas_i,
    input wire logic start_o,
    input wire logic trip_o,
    input wire logic blocked_o,
    input wire logic [1:0] cond_o,
    input wire logic [5:0] evt_o,
    input wire logic disp_evt_o
);
    import psc_pkg::*;
    // =========================================================
    // Bus and stage properties
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);
    a_pready_next: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("pready late");
    a_pready_pulse: assert property (pready_o |=> !pready_o)
        else $error("pready too long");
    a_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("pslverr without pready");
    a_cond_trip: assert property (trip_o |-> cond_o == COND_TRIP)
        else $error("cond not trip");
    a_cond_block: assert property (blocked_o && !trip_o |-> cond_o == COND_BLOCKED)
        else $error("cond not blocked");
    a_start_excl: assert property (!(start_o && blocked_o))
        else $error("start with blocked");
    a_start_evt: assert property (evt_o[0] |-> $rose(start_o))
        else $error("start event without edge");
    a_trip_off_evt: assert property (evt_o[3] |-> $fell(trip_o))
        else $error("trip off event without edge");
    a_disp_evt: assert property (disp_evt_o |-> $rose(blocked_o))
        else $error("display event without block");
    a_trip_cause: assert property ($rose(trip_o) |-> $past(start_o))
        else $error("trip without start");
    a_start_cycle: assert property ($rose(start_o) |-> $past(meas_i.cycle, 2)
        || $past(meas_i.cycle, 3) || $past(meas_i.cycle, 4))
        else $error("start outside cycle");
endmodule

bind psc_stage psc_stage_properties #(.MS_CYCLES(MS_CYCLES)) u_props (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .meas_i(meas_i), .start_o(start_o),
    .trip_o(trip_o), .blocked_o(blocked_o), .cond_o(cond_o), .evt_o(evt_o),
    .disp_evt_o(disp_evt_o));

// ---- psc_meas_src.sv ----
module psc_meas_src #(
    parameter int PER = 5
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [31:0] val_i,
    input wire logic blk_i,
    output psc_pkg::psc_meas_t meas_o,
    output logic block_o
);
    import psc_pkg::*;
    int cnt;
    // =========================================================
    // Program cycle and measurement
    always_ff @(posedge mclk_i) begin
        cnt <= (!rst_b_i || cnt == PER - 1) ? 0 : cnt + 1;
    end
    always_comb begin
        meas_o.val = '0;
        meas_o.val[0] = val_i;
        meas_o.cycle = rst_b_i && cnt == 0;
    end
    // Block valid only at cycle start, toggles elsewhere
    assign block_o = meas_o.cycle ? blk_i : cnt[0];
endmodule

// ---- tb_top.sv ----
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import psc_pkg::*;
    localparam int PU = 1000;
    logic mclk_i, rst_b_i, psel, penable, pwrite, pready, pslverr, err;
    logic blk, block, start, trip, blocked, disp;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, val, rd, ts;
    logic [1:0] cond;
    logic [5:0] evt;
    psc_meas_t meas;
    int fail_count, compares, seed, cyc, on_cnt, disp_cnt, v, m;
    logic [7:0] ra[6] = '{OFS_CTRL, OFS_PU0, OFS_HY0, 8'h18, OFS_OPD, OFS_RLD};
    logic [31:0] rv[6] = '{CTRL_RST, PU_RST, HY_RST, HY_RST, OPD_RST, RLD_RST};

    psc_stage #(.MS_CYCLES(10)) uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .meas_i(meas),
        .block_i(block), .ts_i(ts), .start_o(start), .trip_o(trip), .blocked_o(blocked),
        .cond_o(cond), .evt_o(evt), .disp_evt_o(disp));
    psc_meas_src #(.PER(5)) u_src (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .val_i(val),
        .blk_i(blk), .meas_o(meas), .block_o(block));

    // =========================================================
    // Clock, monitors, timeout
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        ts <= ts + 32'h1;
        if (rst_b_i && (evt[0] || evt[2] || evt[4])) on_cnt <= on_cnt + 1;
        if (rst_b_i && disp) disp_cnt <= disp_cnt + 1;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end

    // =========================================================
    // Tasks
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        do @(posedge mclk_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task prog(input int n);
        repeat (n * 5) @(posedge mclk_i);
    endtask
    task dstep(input int md, input int p, input int x, input bit e);
        apb(1'b1, OFS_MODE, 32'(md));
        apb(1'b1, OFS_PU0, 32'(p));
        while (cyc % (WIN_MS * 10) != WIN_MS * 5) @(posedge mclk_i);
        val <= 32'(x);
        prog(10);
        chk("delta", {31'h0, start}, {31'h0, e});
        prog(30);
        chk("delta settle", {31'h0, start}, 32'h0);
    endtask
    task end_sim;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    function automatic bit exp_pick(input int md, input int x);
        case (md)
            0: return x > PU;
            1: return (x < 0 ? -x : x) > PU;
            2: return x < PU && x >= 0;
            default: return (x < 0 ? -x : x) < PU;
        endcase
    endfunction

    // =========================================================
    // Main sequence
    initial begin
        seed = 32'h0BE5;
        {rst_b_i, psel, penable, pwrite, blk} = '0;
        {paddr, pwdata, val, ts} = '0;
        {cyc, on_cnt, disp_cnt, fail_count, compares} = '0;
        repeat (6) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        foreach (ra[i]) begin
            apb(1'b0, ra[i], 32'h0);
            chk("reset value", rd, rv[i]);
        end
        apb(1'b0, 8'hFC, 32'h0);
        chk("unmapped", {rd[31:1], err}, 32'h1);
        apb(1'b1, OFS_STAT, 32'hF);
        chk("ro write", {31'h0, err}, 32'h1);
        apb(1'b1, OFS_OPD, 32'hFFFF_FFFF);
        apb(1'b0, OFS_OPD, 32'h0);
        chk("opd clip", rd, DLY_MAX);
        apb(1'b1, OFS_PU0, 32'(PU));
        for (int i = 0; i < 24; i++) begin
            m = i % 4;
            v = ($random(seed) % 30) * 100 + 50;
            apb(1'b1, OFS_MODE, 32'(m));
            val <= 32'(v);
            prog(4);
            chk("pick", {31'h0, start}, {31'h0, exp_pick(m, v)});
            chk("cond", {30'h0, cond}, exp_pick(m, v) ? 32'h1 : 32'h0);
        end
        apb(1'b1, OFS_MODE, 32'h0);
        val <= 32'h0;
        prog(4);
        blk <= 1'b1;
        val <= 32'h7D0;
        prog(4);
        chk("blocked", {30'h0, start, blocked}, 32'h1);
        chk("cond blocked", {30'h0, cond}, {30'h0, COND_BLOCKED});
        chk("display", 32'(disp_cnt), 32'h1);
        blk <= 1'b0;
        prog(4);
        chk("unblocked", {30'h0, start, blocked}, 32'h2);
        blk <= 1'b1;
        prog(4);
        chk("late block", {30'h0, start, blocked}, 32'h1);
        blk <= 1'b0;
        apb(1'b1, OFS_CTRL, CTRL_RST | 32'h3);
        prog(4);
        chk("forced", {30'h0, start, blocked}, 32'h1);
        apb(1'b1, OFS_CTRL, CTRL_RST);
        apb(1'b1, OFS_OPD, 32'h2);
        apb(1'b1, OFS_RLD, 32'h3);
        prog(10);
        chk("trip", {31'h0, trip}, 32'h1);
        apb(1'b0, OFS_STAT, 32'h0);
        chk("status", rd & 32'hB, 32'hA);
        val <= 32'h0;
        prog(3);
        chk("trip hold", {31'h0, trip}, 32'h1);
        prog(10);
        chk("trip clear", {31'h0, trip}, 32'h0);
        apb(1'b1, OFS_BL0, 32'h1F4);
        apb(1'b1, OFS_MODE, 32'h2);
        val <= 32'h12C;
        prog(4);
        chk("under limit", {31'h0, start}, 32'h0);
        val <= 32'h2BC;
        prog(4);
        chk("above limit", {31'h0, start}, 32'h1);
        apb(1'b1, OFS_BL0, 32'h0);
        dstep(7, PU, -1500, 1'b1);
        dstep(6, -PU, 0, 1'b0);
        dstep(6, -PU, -1500, 1'b1);
        dstep(5, PU, -PU, 1'b1);
        dstep(4, PU, -800, 1'b1);
        apb(1'b0, OFS_HCNT, 32'h0);
        chk("history", {28'h0, rd[3:0]}, 32'(on_cnt > 12 ? 12 : on_cnt));
        apb(1'b1, OFS_HSEL, 32'((rd[7:4] + 11) % 12));
        apb(1'b0, OFS_HEVT, 32'h0);
        chk("record", {26'h0, rd[31:29], rd[25:23]},
            {26'h0, EV_TRIP_ON, CTRL_RST[CT_SG_LO +: 3]});
        end_sim();
    end
endmodule
